// ==== inc/rcl_cfg.svh ====
// constants for the reset cause and low power block
// assumes a 20 MHz system clock and word-aligned avalon addressing
`ifndef RCL_CFG_SVH
`define RCL_CFG_SVH
// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define RCL_ADDR_FLAGS 12'hFF0
`define RCL_ADDR_PWR 12'hF80
`define RCL_ADDR_STAT 12'hF84
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RCL_BIT_POR 7
`define RCL_BIT_STOP 6
`define RCL_BIT_WDT 5
`define RCL_BIT_EXT 4
`define RCL_RSVD_MASK 8'h0F
`define RCL_UPPER_MASK 8'hF0
`define RCL_FLAGS_RST 8'h80
`define RCL_FLAGS_EXT 8'h10
`define RCL_PWR_RST 8'h88
// ----------------------------------------------------------------
// recovery hold counts (system clock cycles)
// ----------------------------------------------------------------
`define RCL_HOLD_IPO 16'd66
`define RCL_HOLD_XTAL 16'd5000
`define RCL_CNT_W 16
`endif

// ==== inc/rcl_pkg.sv ====
// types shared by the reset cause and low power block
// assumes nothing beyond the cfg header
package rcl_pkg;
   typedef enum logic [3:0] {
      RCL_RUN = 4'b0001,
      RCL_HALT = 4'b0010,
      RCL_STOP = 4'b0100,
      RCL_RECOVER = 4'b1000
   } rcl_mode_t;
endpackage

// ==== inc/rcl_bus_if.sv ====
// interface between the avalon slave and the register core
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface rcl_bus_if;
   logic rd;
   logic wr;
   logic [11:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport slave (output rd, output wr, output addr, output wdata, input rdata);
   modport core (input rd, input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== core/rcl_avs.sv ====
// avalon-mm slave front end: one wait state, registered answer one cycle after the request
// assumes the master holds its request until waitrequest is low
`timescale 1ns/1ps
`default_nettype none
`include "rcl_cfg.svh"
module rcl_avs
   import rcl_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [11:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic avs_waitrequest_o,
   output logic [31:0] avs_readdata_o,
   rcl_bus_if.slave bus
);
   logic ack;
   logic take;
   // ----------------------------------------------------------------
   // handshake
   // ----------------------------------------------------------------
   // a request is taken in its first cycle; ack marks the answer cycle after it
   assign take = (avs_read_i | avs_write_i) & ~ack;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= take;
      end
   end
   // waitrequest is a flop so the top output stays registered; low only in the answer cycle
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= ~take;
      end
   end
   // read data is captured at the edge where the read clear lands, so nothing set is lost
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (take && avs_read_i) begin
         avs_readdata_o <= {24'h000000, bus.rdata};
      end
   end
   assign bus.rd = avs_read_i & take;
   assign bus.wr = avs_write_i & ack; // write lands at the edge the master sees waitrequest low
   assign bus.addr = avs_address_i;
   assign bus.wdata = avs_writedata_i[7:0];
endmodule
`default_nettype wire

// ==== core/rcl_top.sv ====
// reset cause flags and low power mode sequencer
// assumes event inputs are synchronous one-cycle pulses except pins
`timescale 1ns/1ps
`default_nettype none
`include "rcl_cfg.svh"
module rcl_top
   import rcl_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [11:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic avs_waitrequest_o,
   output logic [31:0] avs_readdata_o,
   input wire logic por_evt_i,
   input wire logic ext_pin_rst_i,
   input wire logic wdt_timeout_i,
   input wire logic wdt_reset_cfg_i,
   input wire logic dbg_ctl_rst_i,
   input wire logic debug_line_n_i,
   input wire logic gpio_wake_i,
   input wire logic stop_instr_i,
   input wire logic halt_instr_i,
   input wire logic irq_i,
   input wire logic brownout_rst_i,
   input wire logic xtal_en_i,
   input wire logic wdt_en_i,
   input wire logic bod_stop_opt_i,
   output logic cpu_run_o,
   output logic cpu_rst_o,
   output logic sysclk_en_o,
   output logic osc_en_o,
   output logic xtal_pins_gpio_o,
   output logic wdt_run_o,
   output logic bod_run_o,
   output logic periph_run_o,
   output logic ipo_select_o,
   output logic [7:0] periph_dis_o,
   output logic [7:0] wdt_ctl_o,
   output logic wdt_ctl_wr_o
);
   rcl_bus_if bus();
   rcl_mode_t mode;
   rcl_mode_t next_mode;
   logic [7:0] flags;
   logic [7:0] next_flags;
   logic [7:0] pwr;
   logic [`RCL_CNT_W-1:0] hold_cnt;
   logic [1:0] dbg_sync;
   logic [1:0] gp_sync;
   logic gp_prev;
   logic gp_edge;
   logic dbg_low;
   logic stop_pin_rst;
   logic rec_gpio;
   logic rec_wdt;
   logic [7:0] rdata;

   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   rcl_avs u_avs (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_waitrequest_o(avs_waitrequest_o),
      .avs_readdata_o(avs_readdata_o),
      .bus(bus)
   );

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      hit = (a == b);
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // debug and wake pins are asynchronous, two stages before any logic looks at them
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         dbg_sync <= 2'b11;
         gp_sync <= 2'b00;
         gp_prev <= 1'b0;
      end else begin
         dbg_sync <= {dbg_sync[0], debug_line_n_i};
         gp_sync <= {gp_sync[0], gpio_wake_i};
         gp_prev <= gp_sync[1];
      end
   end
   assign dbg_low = ~dbg_sync[1];
   assign gp_edge = gp_sync[1] ^ gp_prev; // either direction wakes

   // wake events only count while stopped
   assign rec_gpio = (mode == RCL_STOP) & gp_edge & ~wdt_timeout_i;
   assign rec_wdt = (mode == RCL_STOP) & wdt_timeout_i;
   assign stop_pin_rst = (mode == RCL_STOP) & (ext_pin_rst_i | dbg_low);

   // ----------------------------------------------------------------
   // cause flags next value
   // ----------------------------------------------------------------
   // later events in the chain take priority; read clear first so sets win
   always_comb begin
      next_flags = flags;
      if (bus.rd && hit(bus.addr, `RCL_ADDR_FLAGS)) begin
         next_flags = flags & ~`RCL_UPPER_MASK;
      end
      if (wdt_timeout_i && mode != RCL_STOP) begin
         next_flags[`RCL_BIT_POR] = 1'b0;
         next_flags[`RCL_BIT_STOP] = 1'b0;
         next_flags[`RCL_BIT_WDT] = 1'b1;
         if (wdt_reset_cfg_i) begin
            next_flags[`RCL_BIT_EXT] = 1'b0;
         end
      end
      if (rec_wdt) begin
         next_flags[`RCL_BIT_POR] = 1'b0;
         next_flags[`RCL_BIT_STOP] = 1'b1;
         next_flags[`RCL_BIT_WDT] = 1'b1;
      end
      if (rec_gpio) begin
         next_flags[`RCL_BIT_POR] = 1'b0;
         next_flags[`RCL_BIT_STOP] = 1'b1;
         next_flags[`RCL_BIT_WDT] = 1'b0;
         next_flags[`RCL_BIT_EXT] = 1'b0;
      end
      if (ext_pin_rst_i) begin
         next_flags = `RCL_FLAGS_EXT;
      end
      if (dbg_ctl_rst_i || (mode == RCL_STOP && dbg_low)) begin
         next_flags = `RCL_FLAGS_RST;
      end
      if (por_evt_i) begin
         next_flags = `RCL_FLAGS_RST;
      end
      next_flags = next_flags & `RCL_UPPER_MASK;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         flags <= `RCL_FLAGS_RST;
      end else begin
         flags <= next_flags;
      end
   end

   // read data is the pre-clear value
   always_comb begin
      rdata = 8'h00;
      if (hit(bus.addr, `RCL_ADDR_FLAGS)) begin
         rdata = flags;
      end else if (hit(bus.addr, `RCL_ADDR_PWR)) begin
         rdata = pwr;
      end else if (hit(bus.addr, `RCL_ADDR_STAT)) begin
         rdata = {4'h0, mode};
      end
   end
   assign bus.rdata = rdata;

   // ----------------------------------------------------------------
   // writable registers
   // ----------------------------------------------------------------
   // peripheral disables live only through power-on, like the real block
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pwr <= `RCL_PWR_RST;
      end else if (por_evt_i) begin
         pwr <= `RCL_PWR_RST;
      end else if (bus.wr && hit(bus.addr, `RCL_ADDR_PWR)) begin
         pwr <= bus.wdata;
      end
   end

   // writes at the flags address go to watchdog control instead
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wdt_ctl_o <= 8'h00;
         wdt_ctl_wr_o <= 1'b0;
      end else begin
         wdt_ctl_wr_o <= bus.wr && hit(bus.addr, `RCL_ADDR_FLAGS);
         if (bus.wr && hit(bus.addr, `RCL_ADDR_FLAGS)) begin
            wdt_ctl_o <= bus.wdata & ~`RCL_RSVD_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // mode sequencer
   // ----------------------------------------------------------------
   // full resets return to run; a wake leaves stop through recovery, a pin reset goes straight to run
   always_comb begin
      next_mode = mode;
      case (mode)
         RCL_RUN: begin
            if (stop_instr_i) begin
               next_mode = RCL_STOP;
            end else if (halt_instr_i) begin
               next_mode = RCL_HALT;
            end
         end
         RCL_HALT: begin
            if (irq_i || wdt_timeout_i || brownout_rst_i || ext_pin_rst_i) begin
               next_mode = RCL_RUN;
            end
         end
         RCL_STOP: begin
            if (rec_gpio || rec_wdt) begin
               next_mode = RCL_RECOVER;
            end else if (stop_pin_rst) begin
               next_mode = RCL_RUN;
            end
         end
         RCL_RECOVER: begin
            if (hold_cnt == '0) begin
               next_mode = RCL_RUN;
            end
         end
         default: begin
            next_mode = RCL_RUN;
         end
      endcase
      if (por_evt_i || dbg_ctl_rst_i) begin
         next_mode = RCL_RUN;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mode <= RCL_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   // recovery hold: load on entry, count down to zero
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hold_cnt <= '0;
      end else if (mode == RCL_STOP && next_mode == RCL_RECOVER) begin
         hold_cnt <= xtal_en_i ? `RCL_HOLD_XTAL - 16'd1 : `RCL_HOLD_IPO - 16'd1;
      end else if (hold_cnt != '0) begin
         hold_cnt <= hold_cnt - 16'd1;
      end
   end

   // ----------------------------------------------------------------
   // registered control outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cpu_run_o <= 1'b1;
         cpu_rst_o <= 1'b0;
         sysclk_en_o <= 1'b1;
         osc_en_o <= 1'b1;
         xtal_pins_gpio_o <= 1'b0;
         wdt_run_o <= 1'b0;
         bod_run_o <= 1'b1;
         periph_run_o <= 1'b1;
         periph_dis_o <= `RCL_PWR_RST;
      end else begin
         cpu_run_o <= (next_mode == RCL_RUN);
         cpu_rst_o <= (next_mode == RCL_RECOVER);
         sysclk_en_o <= (next_mode != RCL_STOP);
         osc_en_o <= (next_mode != RCL_STOP);
         xtal_pins_gpio_o <= (next_mode == RCL_STOP) | ~xtal_en_i;
         wdt_run_o <= wdt_en_i;
         bod_run_o <= (next_mode != RCL_STOP) | bod_stop_opt_i;
         periph_run_o <= (next_mode != RCL_STOP);
         periph_dis_o <= pwr;
      end
   end

   // recovery forces the internal fast oscillator; software moves it later
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ipo_select_o <= 1'b1;
      end else if (next_mode == RCL_RECOVER) begin
         ipo_select_o <= 1'b1;
      end else if (bus.wr && hit(bus.addr, `RCL_ADDR_STAT)) begin
         ipo_select_o <= bus.wdata[0];
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_read_clear;
      @(posedge clk_i) disable iff (sys_rst_i)
      (bus.rd && hit(bus.addr, `RCL_ADDR_FLAGS) && !por_evt_i && !ext_pin_rst_i && !wdt_timeout_i
         && !dbg_ctl_rst_i && mode != RCL_STOP) |=> (flags == 8'h00);
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");
   property p_reserved;
      @(posedge clk_i) disable iff (sys_rst_i) (flags[3:0] == 4'h0);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved flag bits set");
   property p_por;
      @(posedge clk_i) disable iff (sys_rst_i) por_evt_i |=> (flags == 8'h80) && (mode == RCL_RUN);
   endproperty
   a_por: assert property (p_por) else $error("power-on flags wrong");
   property p_ext;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ext_pin_rst_i && !por_evt_i && !dbg_ctl_rst_i && !(mode == RCL_STOP && dbg_low)) |=> flags == 8'h10;
   endproperty
   a_ext: assert property (p_ext) else $error("external flags wrong");
   property p_wdt_rec;
      @(posedge clk_i) disable iff (sys_rst_i)
      (rec_wdt && !ext_pin_rst_i && !por_evt_i && !dbg_ctl_rst_i && !dbg_low) |=> flags[6:5] == 2'b11;
   endproperty
   a_wdt_rec: assert property (p_wdt_rec) else $error("watchdog recovery flags wrong");
   property p_dbg;
      @(posedge clk_i) disable iff (sys_rst_i) (dbg_ctl_rst_i && !por_evt_i) |=> flags == 8'h80;
   endproperty
   a_dbg: assert property (p_dbg) else $error("debugger reset flags wrong");
   property p_stop_clk;
      @(posedge clk_i) disable iff (sys_rst_i) (mode == RCL_STOP) |-> !sysclk_en_o && !cpu_run_o;
   endproperty
   a_stop_clk: assert property (p_stop_clk) else $error("clock running in stop");
   property p_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      (mode == RCL_STOP && next_mode == RCL_RECOVER && !xtal_en_i && !por_evt_i && !dbg_ctl_rst_i)
         |=> (mode == RCL_RECOVER) [*8] ##58 (mode == RCL_RECOVER) ##1 (mode == RCL_RUN); // 66 cycles exactly
   endproperty
   a_hold: assert property (p_hold) else $error("recovery hold length wrong");
   property p_halt_exit;
      @(posedge clk_i) disable iff (sys_rst_i) (mode == RCL_HALT && irq_i) |=> mode == RCL_RUN;
   endproperty
   a_halt_exit: assert property (p_halt_exit) else $error("halt not left on interrupt");
   c_halt: cover property (@(posedge clk_i) mode == RCL_HALT ##1 mode == RCL_RUN);
   c_recover: cover property (@(posedge clk_i) mode == RCL_RECOVER ##1 mode == RCL_RUN);
   c_read: cover property (@(posedge clk_i) bus.rd && flags != 8'h00);
endmodule
`default_nettype wire

// ==== tb/rcl_top_tb.sv ====
// self-checking bench for the reset cause flags and low power sequencer
// assumes the design files and rcl_cfg.svh are compiled first; single 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "rcl_cfg.svh"
module rcl_top_tb
   import rcl_pkg::*;
;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [11:0] avs_address_i = 12'h000;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h00000000;
   logic avs_waitrequest_o;
   logic [31:0] avs_readdata_o;
   logic [7:0] ev = 8'h00;
   logic wdt_reset_cfg_i = 1'b1;
   logic debug_line_n_i = 1'b1;
   logic gpio_wake_i = 1'b0;
   logic xtal_en_i = 1'b0;
   logic wdt_en_i = 1'b1;
   logic bod_stop_opt_i = 1'b1;
   logic cpu_run_o, cpu_rst_o, sysclk_en_o, osc_en_o, xtal_pins_gpio_o;
   logic wdt_run_o, bod_run_o, periph_run_o, ipo_select_o, wdt_ctl_wr_o;
   logic [7:0] periph_dis_o;
   logic [7:0] wdt_ctl_o;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [7:0] q;
   int n;
   // event pulse lanes
   localparam logic [7:0] E_POR = 8'h01, E_EXT = 8'h02, E_WDT = 8'h04, E_DBG = 8'h08;
   localparam logic [7:0] E_STOP = 8'h10, E_HALT = 8'h20, E_IRQ = 8'h40, E_BOD = 8'h80;

   rcl_top dut_u (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
      .avs_readdata_o(avs_readdata_o),
      .por_evt_i(ev[0]), .ext_pin_rst_i(ev[1]), .wdt_timeout_i(ev[2]), .wdt_reset_cfg_i(wdt_reset_cfg_i),
      .dbg_ctl_rst_i(ev[3]), .debug_line_n_i(debug_line_n_i), .gpio_wake_i(gpio_wake_i),
      .stop_instr_i(ev[4]), .halt_instr_i(ev[5]), .irq_i(ev[6]), .brownout_rst_i(ev[7]),
      .xtal_en_i(xtal_en_i), .wdt_en_i(wdt_en_i), .bod_stop_opt_i(bod_stop_opt_i),
      .cpu_run_o(cpu_run_o), .cpu_rst_o(cpu_rst_o), .sysclk_en_o(sysclk_en_o), .osc_en_o(osc_en_o),
      .xtal_pins_gpio_o(xtal_pins_gpio_o), .wdt_run_o(wdt_run_o), .bod_run_o(bod_run_o),
      .periph_run_o(periph_run_o), .ipo_select_o(ipo_select_o), .periph_dis_o(periph_dis_o),
      .wdt_ctl_o(wdt_ctl_o), .wdt_ctl_wr_o(wdt_ctl_wr_o)
   );

   // ----------------------------------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial begin
      forever #25 clk_i = ~clk_i;
   end

   // ceiling covers one long recovery hold, two short ones and the register traffic
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon access; the request is held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] rd);
      int k;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_read_i <= ~wr;
      avs_write_i <= wr;
      avs_writedata_i <= {24'h000000, d};
      k = 0;
      do begin
         @(posedge clk_i);
         k = k + 1;
      end while (avs_waitrequest_o !== 1'b0 && k < 20);
      // a request that never gets its answer counts as a mismatch
      if (avs_waitrequest_o !== 1'b0) chk(32'h00000001, 32'h00000000);
      rd = avs_readdata_o[7:0];
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] v;
      bus(1'b0, a, 8'h00, v);
      chk({24'h000000, v}, {24'h000000, exp});
   endtask

   // one-cycle event pulse, then let registered outputs settle
   task automatic pulse(input logic [7:0] m);
      @(posedge clk_i);
      ev <= m;
      @(posedge clk_i);
      ev <= 8'h00;
      repeat (4) @(posedge clk_i);
   endtask

   // counts the cycles the cpu is held in reset after a recovery starts
   task automatic hold_count(output int c);
      int k;
      c = 0;
      for (k = 0; k < 50 && cpu_rst_o !== 1'b1; k++) @(negedge clk_i);
      for (k = 0; k < 6000 && cpu_rst_o === 1'b1; k++) begin
         c = c + 1;
         @(negedge clk_i);
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd_chk(`RCL_ADDR_FLAGS, `RCL_FLAGS_RST);
      rd_chk(`RCL_ADDR_FLAGS, 8'h00);
      rd_chk(`RCL_ADDR_PWR, `RCL_PWR_RST);
      bus(1'b1, `RCL_ADDR_PWR, 8'h12, q);
      rd_chk(`RCL_ADDR_PWR, 8'h12);
      chk({24'h0, periph_dis_o}, 32'h00000012);
      rd_chk(12'h004, 8'h00);
      // shared address: the write lands in watchdog control, flags untouched
      bus(1'b1, `RCL_ADDR_FLAGS, 8'hA0, q);
      @(posedge clk_i);
      chk({24'h0, wdt_ctl_o}, 32'h000000A0);
      chk({31'h0, wdt_ctl_wr_o}, 32'h00000001);
      rd_chk(`RCL_ADDR_FLAGS, 8'h00);
      pulse(E_EXT);
      rd_chk(`RCL_ADDR_FLAGS, 8'h10);
      pulse(E_POR);
      pulse(E_WDT);
      rd_chk(`RCL_ADDR_FLAGS, 8'h20);
      bus(1'b1, `RCL_ADDR_STAT, 8'h00, q);
      @(posedge clk_i);
      chk({31'h0, ipo_select_o}, 32'h00000000);
      // pin recovery with crystal off then on; a pending watchdog flag must drop
      for (int x = 0; x < 2; x++) begin
         xtal_en_i <= x[0];
         wdt_en_i <= x[0];
         bod_stop_opt_i <= x[0];
         pulse(E_WDT);
         pulse(E_STOP);
         chk({28'h0, cpu_run_o, sysclk_en_o, osc_en_o, xtal_pins_gpio_o}, 32'h00000001);
         chk({29'h0, wdt_run_o, bod_run_o, periph_run_o}, (x == 0) ? 32'h00000000 : 32'h00000006);
         rd_chk(`RCL_ADDR_STAT, {4'h0, RCL_STOP});
         pulse(E_IRQ);
         rd_chk(`RCL_ADDR_STAT, {4'h0, RCL_STOP});
         gpio_wake_i <= ~gpio_wake_i;
         hold_count(n);
         chk(n, (x == 0) ? `RCL_HOLD_IPO : `RCL_HOLD_XTAL);
         chk({31'h0, ipo_select_o}, 32'h00000001);
         rd_chk(`RCL_ADDR_FLAGS, 8'h40);
         rd_chk(`RCL_ADDR_STAT, {4'h0, RCL_RUN});
      end
      xtal_en_i <= 1'b0;
      pulse(E_STOP);
      pulse(E_WDT);
      hold_count(n);
      rd_chk(`RCL_ADDR_FLAGS, 8'h60);
      // debug line low while stopped acts as a full reset
      pulse(E_STOP);
      debug_line_n_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      debug_line_n_i <= 1'b1;
      repeat (80) @(posedge clk_i);
      rd_chk(`RCL_ADDR_FLAGS, 8'h80);
      rd_chk(`RCL_ADDR_STAT, {4'h0, RCL_RUN});
      pulse(E_DBG);
      rd_chk(`RCL_ADDR_FLAGS, 8'h80);
      // every documented halt exit; watchdog in its interrupt setting
      wdt_reset_cfg_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         pulse(E_HALT);
         chk({29'h0, cpu_run_o, sysclk_en_o, periph_run_o}, 32'h00000003);
         rd_chk(`RCL_ADDR_STAT, {4'h0, RCL_HALT});
         pulse(i == 0 ? E_IRQ : i == 1 ? E_WDT : i == 2 ? E_BOD : i == 3 ? E_EXT : E_POR);
         repeat (80) @(posedge clk_i);
         rd_chk(`RCL_ADDR_STAT, {4'h0, RCL_RUN});
         rd_chk(`RCL_ADDR_FLAGS, i == 1 ? 8'h20 : i == 3 ? 8'h10 : i == 4 ? `RCL_FLAGS_RST : 8'h00);
      end
      complete_run();
   end
endmodule
`default_nettype wire
